// *** rtl/rops_apb_slave.sv ***
// Purpose: APB slave front end with one wait state and an error answer.
// Assumes: Master holds the request until pready is seen high.
// Notes: Produces a one-cycle commit strobe for writes to a decoded address only.
`timescale 1ns/100ps
`default_nettype none
module rops_apb_slave (
  input wire logic clk,
  input wire logic rst_b,
  input wire rops_pkg::rops_apb_req_t req,
  input wire logic addr_hit,
  input wire logic [31:0] rd_word,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic wr_commit
);
  rops_pkg::rops_state_t state;
  rops_pkg::rops_state_t next_state;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;

  // The answer is registered one cycle into the access phase.
  always_comb begin
    next_state = state;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    wr_commit = 1'b0;
    case (state)
      rops_pkg::ROPS_IDLE: begin
        if (req.sel && req.enable) begin
          next_state = rops_pkg::ROPS_ACCESS;
          next_pready = 1'b1;
          next_pslverr = !addr_hit;
          next_prdata = (addr_hit && !req.write) ? rd_word : 32'h00000000;
        end
      end
      rops_pkg::ROPS_ACCESS: begin
        next_state = rops_pkg::ROPS_DONE;
        wr_commit = req.write && addr_hit;
      end
      rops_pkg::ROPS_DONE: begin
        next_state = rops_pkg::ROPS_IDLE;
      end
      default: begin
        next_state = rops_pkg::ROPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= rops_pkg::ROPS_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      state <= next_state;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end
endmodule
`default_nettype wire

// *** rtl/rops_pin_mux.sv ***
// Purpose: One remappable pin driven by the selected peripheral function.
// Assumes: Function inputs are on the same clock as this block.
// Notes: Code zero releases the pin to ordinary port logic.
`timescale 1ns/100ps
`default_nettype none
module rops_pin_mux (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [5:0] sel,
  input wire logic [63:0] func_out,
  input wire logic port_out,
  output logic pin_out,
  output logic pin_remapped
);
  logic next_pin_out;
  logic next_pin_remapped;

  always_comb begin
    next_pin_remapped = (sel != rops_pkg::ROPS_SEL_NONE);
    next_pin_out = next_pin_remapped ? func_out[sel] : port_out;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= 1'b0;
      pin_remapped <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      pin_remapped <= next_pin_remapped;
    end
  end
endmodule
`default_nettype wire

// *** rtl/rops_pkg.sv ***
// Purpose: Shared constants and types for the remappable output pin select.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Function codes are six bits; code zero means no peripheral.
package rops_pkg;
  localparam int unsigned ROPS_ADDR_W = 12;
  localparam int unsigned ROPS_SEL_W = 6;
  localparam int unsigned ROPS_FUNC_N = 64;
  localparam int unsigned ROPS_PIN_N = 4;
  localparam logic [11:0] ROPS_OFS_SEL0 = 12'h000;
  localparam logic [11:0] ROPS_OFS_SEL1 = 12'h004;
  localparam int unsigned ROPS_HI_LSB = 8;
  localparam int unsigned ROPS_LO_LSB = 0;
  localparam logic [5:0] ROPS_SEL_RESET = 6'h00;
  localparam logic [5:0] ROPS_SEL_NONE = 6'h00;
  localparam logic [15:0] ROPS_IMPL_MASK = 16'h3f3f;
  localparam int unsigned ROPS_PIN20 = 0;
  localparam int unsigned ROPS_PIN35 = 1;
  localparam int unsigned ROPS_PIN36 = 2;
  localparam int unsigned ROPS_PIN37 = 3;

  typedef struct packed {
    logic [5:0] pin35_function_sel;
    logic [5:0] pin20_function_sel;
  } rops_sel0_t;

  typedef struct packed {
    logic [5:0] pin37_function_sel;
    logic [5:0] pin36_function_sel;
  } rops_sel1_t;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } rops_apb_req_t;

  typedef enum logic [1:0] {
    ROPS_IDLE = 2'b00,
    ROPS_ACCESS = 2'b01,
    ROPS_DONE = 2'b10
  } rops_state_t;
endpackage

// *** rtl/rops_top.sv ***
// Purpose: Output side of the peripheral pin select crossbar with APB access.
// Assumes: APB master on clk; peripheral and port outputs on clk as well.
// Notes: Two 16-bit select registers sit in the low half of their words.
//
// Overview of operation
// R1: Select register 0 bits 13..8 choose the function on pin 35.
// R2: Select register 0 bits 5..0 choose the function on pin 20.
// R3: Select register 1 bits 13..8 choose the function on pin 37.
// R4: Select register 1 bits 5..0 choose the function on pin 36.
// R5: Bits 15..14 and 7..6 read zero and ignore writes.
// R6: Selectors reset to zero; zero leaves the pin to port logic.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module rops_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic [63:0] func_out,
  input wire logic [3:0] port_out,
  output logic remap_pin_20,
  output logic remap_pin_35,
  output logic remap_pin_36,
  output logic remap_pin_37,
  output logic [3:0] pin_remapped
);
  rops_pkg::rops_sel0_t output_select_0;
  rops_pkg::rops_sel1_t output_select_1;
  rops_pkg::rops_sel0_t next_output_select_0;
  rops_pkg::rops_sel1_t next_output_select_1;
  rops_pkg::rops_apb_req_t req;
  logic addr_hit;
  logic wr_commit;
  logic [31:0] rd_word;
  logic [15:0] wr_half;
  logic [3:0] pin_value;
  logic [5:0] pin_sel [4];

  // Packs two six-bit fields into a 16-bit register image.
  function automatic logic [15:0] rops_pack(input logic [5:0] hi,
                                            input logic [5:0] lo);
    logic [15:0] v;
    v = 16'h0000;
    v[rops_pkg::ROPS_HI_LSB +: 6] = hi;
    v[rops_pkg::ROPS_LO_LSB +: 6] = lo;
    rops_pack = v & rops_pkg::ROPS_IMPL_MASK; // see R5
  endfunction

  // One driver for the whole request word keeps the struct single-driven.
  assign req = {psel, penable, pwrite, paddr, pwdata};

  // Address decode and read mux.
  always_comb begin
    addr_hit = 1'b0;
    rd_word = 32'h00000000;
    if (paddr == rops_pkg::ROPS_OFS_SEL0) begin
      addr_hit = 1'b1;
      rd_word = {16'h0000, rops_pack(output_select_0.pin35_function_sel,
                 output_select_0.pin20_function_sel)}; // see R5
    end else if (paddr == rops_pkg::ROPS_OFS_SEL1) begin
      addr_hit = 1'b1;
      rd_word = {16'h0000, rops_pack(output_select_1.pin37_function_sel,
                 output_select_1.pin36_function_sel)}; // see R5
    end
  end

  rops_apb_slave u_apb (
    .clk(clk),
    .rst_b(rst_b),
    .req(req),
    .addr_hit(addr_hit),
    .rd_word(rd_word),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .wr_commit(wr_commit)
  );

  // Write path honours byte strobes; only implemented bits are kept.
  always_comb begin
    wr_half = 16'h0000;
    next_output_select_0 = output_select_0;
    next_output_select_1 = output_select_1;
    if (wr_commit && paddr == rops_pkg::ROPS_OFS_SEL0) begin
      wr_half = pwdata[15:0] & rops_pkg::ROPS_IMPL_MASK; // see R5
      if (pstrb[1]) begin
        next_output_select_0.pin35_function_sel =
          wr_half[rops_pkg::ROPS_HI_LSB +: 6]; // see R1
      end
      if (pstrb[0]) begin
        next_output_select_0.pin20_function_sel =
          wr_half[rops_pkg::ROPS_LO_LSB +: 6]; // see R2
      end
    end else if (wr_commit && paddr == rops_pkg::ROPS_OFS_SEL1) begin
      wr_half = pwdata[15:0] & rops_pkg::ROPS_IMPL_MASK; // see R5
      if (pstrb[1]) begin
        next_output_select_1.pin37_function_sel =
          wr_half[rops_pkg::ROPS_HI_LSB +: 6]; // see R3
      end
      if (pstrb[0]) begin
        next_output_select_1.pin36_function_sel =
          wr_half[rops_pkg::ROPS_LO_LSB +: 6]; // see R4
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      output_select_0 <= {rops_pkg::ROPS_SEL_RESET,
                          rops_pkg::ROPS_SEL_RESET}; // see R6
      output_select_1 <= {rops_pkg::ROPS_SEL_RESET,
                          rops_pkg::ROPS_SEL_RESET}; // see R6
    end else begin
      output_select_0 <= next_output_select_0;
      output_select_1 <= next_output_select_1;
    end
  end

  assign pin_sel[rops_pkg::ROPS_PIN20] = output_select_0.pin20_function_sel;
  assign pin_sel[rops_pkg::ROPS_PIN35] = output_select_0.pin35_function_sel;
  assign pin_sel[rops_pkg::ROPS_PIN36] = output_select_1.pin36_function_sel;
  assign pin_sel[rops_pkg::ROPS_PIN37] = output_select_1.pin37_function_sel;

  // Each pin routes its chosen function, or port logic on code zero.
  genvar gi;
  generate
    for (gi = 0; gi < rops_pkg::ROPS_PIN_N; gi++) begin : g_pin
      rops_pin_mux u_mux (
        .clk(clk),
        .rst_b(rst_b),
        .sel(pin_sel[gi]),
        .func_out(func_out),
        .port_out(port_out[gi]),
        .pin_out(pin_value[gi]),
        .pin_remapped(pin_remapped[gi])
      ); // see R1 R2 R3 R4 R6
    end
  endgenerate

  assign remap_pin_20 = pin_value[rops_pkg::ROPS_PIN20];
  assign remap_pin_35 = pin_value[rops_pkg::ROPS_PIN35];
  assign remap_pin_36 = pin_value[rops_pkg::ROPS_PIN36];
  assign remap_pin_37 = pin_value[rops_pkg::ROPS_PIN37];
endmodule
`default_nettype wire

// *** test/remappable_output_pin_select_bench.sv ***
// Purpose: Register, strobe, error and reset tests of the pin select.
// Assumes: Checker bound to rops_top watches the pins throughout.
// Notes: Upper data half mirrors the lower to prove it is ignored.
`timescale 1ns/100ps
`default_nettype none
module remappable_output_pin_select_bench;
  typedef struct packed {
    logic [11:0] a;
    logic [3:0] s;
    logic [15:0] d;
    logic [15:0] x;
  } rops_row_t;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic p20, p35, p36, p37;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, pin_remapped, port_out;
  logic [63:0] func_out;
  int err_count, tests_run;
  rops_row_t rows [7] = '{'{12'h000, 4'h0, 16'hffff, 16'h0000},
    '{12'h004, 4'h0, 16'hffff, 16'h0000},
    '{12'h000, 4'hf, 16'hffff, 16'h3f3f},
    '{12'h000, 4'h1, 16'h0000, 16'h3f00},
    '{12'h000, 4'h2, 16'h2a15, 16'h2a00},
    '{12'h004, 4'hf, 16'h1525, 16'h1525},
    '{12'h004, 4'h2, 16'hc0ff, 16'h0025}};
  rops_top uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .func_out(func_out), .port_out(port_out), .remap_pin_20(p20),
    .remap_pin_35(p35), .remap_pin_36(p36), .remap_pin_37(p37),
    .pin_remapped(pin_remapped));
  rops_periph_model u_model (.clk(clk), .rst_b(rst_b),
    .func_out(func_out), .port_out(port_out));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task give_verdict;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [15:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {d, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      give_verdict();
    end
  endtask
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
      apb(1'b0, rows[i].a, 16'h0000, 4'h0);
      chk("readback", rd, {16'h0000, rows[i].x});
    end
    apb(1'b1, 12'h008, 16'h3f3f, 4'hf);
    chk("unmapped error", {31'h0, er}, 32'h1);
    chk("remap flags", {28'h0, pin_remapped}, 32'h6);
    rst_b <= 1'b0;
    @(posedge clk);
    chk("remap in reset", {28'h0, pin_remapped}, 32'h0);
    rst_b <= 1'b1;
    apb(1'b0, 12'h000, 16'h0000, 4'h0);
    chk("select after reset", rd, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire

// *** test/rops_periph_model.sv ***
// Purpose: Peripheral outputs and port values that keep changing.
// Assumes: Same clock as the pin select.
// Notes: A twisted ring gives every function bit a changing level.
`timescale 1ns/100ps
`default_nettype none
module rops_periph_model (
  input wire logic clk,
  input wire logic rst_b,
  output logic [63:0] func_out,
  output logic [3:0] port_out
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      func_out <= 64'h0f0f_3c3c_5a5a_9669;
      port_out <= 4'h5;
    end else begin
      func_out <= {func_out[62:0], ~func_out[63]};
      port_out <= ~port_out;
    end
  end
endmodule
`default_nettype wire

// *** test/rops_top_checker.sv ***
// Purpose: Assertions on selector readback, pin routing and remap flags.
// Assumes: Bound to rops_top; a write lands on the edge that sees pready.
// Notes: Shadow selectors predict every pin one cycle after a write.
`timescale 1ns/100ps
`default_nettype none
module rops_top_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic [63:0] func_out,
  input wire logic [3:0] port_out,
  input wire logic remap_pin_20,
  input wire logic remap_pin_35,
  input wire logic remap_pin_36,
  input wire logic remap_pin_37,
  input wire logic [3:0] pin_remapped
);
  logic [15:0] s0, s1, m;
  logic [7:0] ep;
  logic wr;
  assign m = {{8{pstrb[1]}}, {8{pstrb[0]}}} & rops_pkg::ROPS_IMPL_MASK;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  function automatic logic pick(logic [5:0] c, logic p);
    return (c != 6'h00) ? func_out[c] : p;
  endfunction
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s0 <= 16'h0000;
      s1 <= 16'h0000;
      ep <= 8'h00;
    end else begin
      if (wr && paddr == rops_pkg::ROPS_OFS_SEL0) begin
        s0 <= (s0 & ~m) | (pwdata[15:0] & m);
      end
      if (wr && paddr == rops_pkg::ROPS_OFS_SEL1) begin
        s1 <= (s1 & ~m) | (pwdata[15:0] & m);
      end
      ep <= {s1[13:8] != 6'h00, s1[5:0] != 6'h00, s0[13:8] != 6'h00,
        s0[5:0] != 6'h00, pick(s1[13:8], port_out[3]),
        pick(s1[5:0], port_out[2]), pick(s0[13:8], port_out[1]),
        pick(s0[5:0], port_out[0])};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_pin35; remap_pin_35 == ep[1]; endproperty
  a_pin35: assert property (p_pin35) else $error("bad pin 35");
  property p_pin20; remap_pin_20 == ep[0]; endproperty
  a_pin20: assert property (p_pin20) else $error("bad pin 20");
  property p_pin37; remap_pin_37 == ep[3]; endproperty
  a_pin37: assert property (p_pin37) else $error("bad pin 37");
  property p_pin36; remap_pin_36 == ep[2]; endproperty
  a_pin36: assert property (p_pin36) else $error("bad pin 36");
  property p_read; pready && !pwrite && !pslverr |-> prdata ==
    {16'h0000, (paddr == rops_pkg::ROPS_OFS_SEL1) ? s1 : s0}; endproperty
  a_read: assert property (p_read) else $error("bad readback");
  property p_remap; pin_remapped == ep[7:4]; endproperty
  a_remap: assert property (p_remap) else $error("bad remap flag");
endmodule
bind rops_top rops_top_checker u_chk (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .func_out(func_out), .port_out(port_out),
  .remap_pin_20(remap_pin_20), .remap_pin_35(remap_pin_35),
  .remap_pin_36(remap_pin_36), .remap_pin_37(remap_pin_37),
  .pin_remapped(pin_remapped));
`default_nettype wire
